/* File: inc/adpf_pkg.sv */
// Purpose: shared constants and types of the dc/peak/fade/dither audio block
// Assumes: 20-bit signed two's complement audio, full scale at 2^19
// Notes:   register indices are Avalon word addresses
package adpf_pkg;

	localparam int AW = 20;                          // audio word width
	localparam int EW = 24;                          // shaper error width

	// register word addresses
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_FADE = 3'h1;
	localparam logic [2:0] ADDR_PEAK = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;

	// control register bit positions
	localparam int CTRL_DC_ON    = 0;
	localparam int CTRL_DC_TRACK = 1;
	localparam int CTRL_FADE_ACT = 2;
	localparam int CTRL_NOISE_ON = 3;
	localparam int CTRL_ORDER    = 4;
	localparam int CTRL_W        = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h03;

	// fade and status register field positions
	localparam int FADE_TGT_LSB = 0;
	localparam int FADE_FSS_LSB = 16;
	localparam int STAT_GAIN_LSB = 0;
	localparam int STAT_CODE_LSB = 16;
	localparam logic [9:0] TGT_RST = 10'h000;
	localparam logic [9:0] FSS_RST = 10'h000;

	// dc filter: first-order low-pass branch at 2 Hz on the 2x stream
	localparam int DC_CORNER_HZ = 2;
	localparam int BASE_FS_HZ   = 44100;
	localparam int DC_SHIFT     = $clog2((2 * BASE_FS_HZ * 100) / (628 * DC_CORNER_HZ));
	localparam int LPW          = AW + DC_SHIFT;

	// peak and volume constants
	localparam logic [15:0] PEAK_MAX   = 16'h7d72;
	localparam logic [14:0] GAIN_MAX   = 15'h7fff;
	localparam logic [9:0]  CODE_MUTE  = 10'h3ff;
	localparam logic [10:0] FSS_OFFSET = 11'h002;

	// final scaling as a q15 factor, and dither in units of the audio lsb
	localparam logic [15:0] SCALE_3DB = 16'h5a82;
	localparam logic signed [AW-1:0] DITHER_HI = 20'sh06000;
	localparam logic signed [AW-1:0] DITHER_LO = 20'shfe000;

	// shaper clock divider default
	localparam int SHAPER_DIV_DEF = 8;

	typedef struct packed {
		logic signed [AW-1:0] left;
		logic signed [AW-1:0] right;
	} adpf_pair_t;

	typedef struct packed {
		logic                              wreq;
		logic [31:0]                       rdata;
		logic [CTRL_W-1:0]                 ctrl;
		logic [9:0]                        target;
		logic [9:0]                        fade_step_delay;
		logic [1:0][LPW-1:0]               lp;
		logic                              fs_phase;
		logic [1:0][15:0]                  peak;
		logic [10:0]                       step_cnt;
		logic [9:0]                        cur_code;
		logic [14:0]                       exp_pt;
		logic [14:0]                       gain;
		logic                              mid_valid;
		adpf_pair_t                        mid;
		logic                              dith_ph;
		logic [1:0][AW-1:0]                ns_v;
		logic [1:0][3:0][EW-1:0]           err;
		logic [7:0]                        div_cnt;
		logic [1:0]                        bits;
	} adpf_state_t;

endpackage : adpf_pkg

/* File: rtl/adpf_top.sv */
// Purpose: dc-cancel, peak detect, fade volume, scaling, dither and bitstream shaper
// Assumes: audio strobes come from logic on core_clk; one sample pair per strobe
// Notes:   registers on Avalon-MM, every access answered after one wait cycle
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module adpf_top
	import adpf_pkg::*;
#(
	parameter int SHAPER_DIV = SHAPER_DIV_DEF
)(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// avalon-mm register slave
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// 2x stream from the first half-band stage
	input  wire logic        in_valid,
	input  wire adpf_pair_t  in_pair,
	// 2x stream towards the second half-band stage
	output logic             mid_valid,
	output adpf_pair_t       mid_pair,
	// 8x stream from the third half-band stage
	input  wire logic        os_valid,
	input  wire adpf_pair_t  os_pair,
	// one-bit converter outputs, bit 0 left, bit 1 right
	output logic [1:0]       bit_out,
	output logic             shaper_order_sel
);

	if (SHAPER_DIV < 2 || SHAPER_DIV > 255)
	begin : g_bad_div
		$error("SHAPER_DIV must lie in 2..255");
	end

	adpf_state_t s_q;
	adpf_state_t s_d;

	// saturate a wide value to the audio word
	function automatic logic signed [AW-1:0] sat_aw(input logic signed [39:0] v);
		if (v > 40'sh0007ffff)
			return 20'sh7ffff;
		else if (v < -40'sh00080000)
			return 20'sh80000;
		else
			return v[AW-1:0];
	endfunction : sat_aw

	// audio times an unsigned q15 factor
	function automatic logic signed [AW-1:0] mul_q15(
		input logic signed [AW-1:0] x,
		input logic [15:0]          g
	);
		logic signed [36:0] p;
		p = x * $signed({1'b0, g});
		return sat_aw(40'(p >>> 15));
	endfunction : mul_q15

	// absolute value reduced to 16 bits and clipped to the reachable range
	function automatic logic [15:0] peak_of(input logic signed [AW-1:0] x);
		logic [AW-1:0] a;
		logic [15:0]   t;
		a = x[AW-1] ? AW'(-x) : x;
		t = a[AW-1:AW-16];
		return (t > PEAK_MAX) ? PEAK_MAX : t;
	endfunction : peak_of

	// about 0.1 dB of the current exponential point, at least one lsb
	function automatic logic [14:0] db_step(input logic [14:0] e);
		logic [14:0] d;
		d = (e >> 7) + (e >> 8) + (e >> 10);
		return (d == 15'h0000) ? 15'h0001 : d;
	endfunction : db_step

	always_comb
	begin
		logic        pk_clr;
		logic        rise;
		logic        fs_tick;
		logic [1:0][AW-1:0] x;
		logic signed [AW-1:0] d;
		logic signed [AW-1:0] lp_int;
		logic signed [AW-1:0] y;
		logic [1:0][AW-1:0] yv;
		logic [15:0] pk;
		logic [10:0] cnt;
		logic signed [AW-1:0] dv;
		logic signed [AW-1:0] sc;
		logic signed [EW+3:0] u;
		logic signed [EW+3:0] fb;
		logic signed [EW+3:0] q;
		logic signed [EW+3:0] lim;
		pk_clr  = 1'b0;
		rise    = 1'b0;
		fs_tick = 1'b0;
		x       = '0;
		d       = '0;
		lp_int  = '0;
		y       = '0;
		yv      = '0;
		pk      = '0;
		cnt     = '0;
		dv      = '0;
		sc      = '0;
		u       = '0;
		fb      = '0;
		q       = '0;
		lim     = (EW+4)'(1) <<< (EW - 2);
		s_d     = s_q;
		s_d.mid_valid = 1'b0;

		// register slave: one wait cycle, then the answer stands for one cycle
		if (s_q.wreq && (avs_read || avs_write))
		begin
			s_d.wreq  = 1'b0;
			s_d.rdata = '0;
			if (avs_write)
			begin
				unique case (avs_address)
					ADDR_CTRL:
					begin
						s_d.ctrl = avs_writedata[CTRL_W-1:0];
						rise = avs_writedata[CTRL_FADE_ACT] && !s_q.ctrl[CTRL_FADE_ACT];
					end
					ADDR_FADE:
					begin
						s_d.target = avs_writedata[FADE_TGT_LSB +: 10];
						s_d.fade_step_delay    = avs_writedata[FADE_FSS_LSB +: 10];
					end
					default:
					begin
					end
				endcase
			end
			else
			begin
				unique case (avs_address)
					ADDR_CTRL:
						s_d.rdata = 32'(s_q.ctrl);
					ADDR_FADE:
					begin
						s_d.rdata[FADE_TGT_LSB +: 10] = s_q.target;
						s_d.rdata[FADE_FSS_LSB +: 10] = s_q.fade_step_delay;
					end
					ADDR_PEAK:
					begin
						s_d.rdata = {s_q.peak[1], s_q.peak[0]};
						pk_clr    = 1'b1;
					end
					ADDR_STAT:
					begin
						s_d.rdata[STAT_GAIN_LSB +: 15] = s_q.gain;
						s_d.rdata[STAT_CODE_LSB +: 10] = s_q.cur_code;
					end
					default:
						s_d.rdata = '0;
				endcase
			end
		end
		else
			s_d.wreq = 1'b1;

		if (pk_clr)
			s_d.peak = '0;

		// a new fade begins from full volume at the current settings
		if (rise)
		begin
			s_d.step_cnt = '0;
			s_d.cur_code = '0;
			s_d.exp_pt   = GAIN_MAX;
		end

		// 2x stream: dc removal, peak and volume
		if (in_valid)
		begin
			s_d.fs_phase = !s_q.fs_phase;
			fs_tick      = s_q.fs_phase;
			x[0] = in_pair.left;
			x[1] = in_pair.right;
			for (int c = 0; c < 2; c++)
			begin
				// arithmetic shift: the branch holds negative dc on a negative channel
				lp_int = AW'($signed(s_q.lp[c]) >>> DC_SHIFT);
				d = s_q.ctrl[CTRL_DC_ON] ? $signed(x[c]) : '0;
				if (s_q.ctrl[CTRL_DC_TRACK])
					s_d.lp[c] = s_q.lp[c] + LPW'(d) - LPW'(lp_int);
				y = sat_aw(40'($signed(x[c])) - 40'(lp_int));
				yv[c] = y;
				if (fs_tick)
				begin
					pk = peak_of(y);
					if (pk > s_d.peak[c])
						s_d.peak[c] = pk;
				end
			end
		end

		// fade engine, stepped once per base sample
		if (fs_tick)
		begin
			if (!s_q.ctrl[CTRL_FADE_ACT])
			begin
				s_d.gain     = GAIN_MAX;
				s_d.step_cnt = '0;
				s_d.cur_code = '0;
				s_d.exp_pt   = GAIN_MAX;
			end
			else
			begin
				cnt = s_d.step_cnt + 11'h001;
				if (cnt >= 11'(s_q.fade_step_delay) + FSS_OFFSET)
				begin
					cnt = '0;
					if (s_d.cur_code < s_q.target)
					begin
						s_d.cur_code = s_d.cur_code + 10'h001;
						if (s_d.cur_code == CODE_MUTE)
							s_d.exp_pt = '0;
						else if (s_d.exp_pt > db_step(s_d.exp_pt))
							s_d.exp_pt = s_d.exp_pt - db_step(s_d.exp_pt);
						else
							s_d.exp_pt = '0;
					end
					else if (s_d.cur_code > s_q.target)
					begin
						s_d.cur_code = s_d.cur_code - 10'h001;
						if (s_d.cur_code == '0 || GAIN_MAX - s_d.exp_pt < db_step(s_d.exp_pt))
							s_d.exp_pt = GAIN_MAX;
						else
							s_d.exp_pt = s_d.exp_pt + db_step(s_d.exp_pt);
					end
				end
				s_d.step_cnt = cnt;
				// one lsb per sample towards the curve, then hold
				if (s_q.gain < s_d.exp_pt)
					s_d.gain = s_q.gain + 15'h0001;
				else if (s_q.gain > s_d.exp_pt)
					s_d.gain = s_q.gain - 15'h0001;
				else
					s_d.gain = s_q.gain;
			end
		end

		// gain applied to the dc-free samples
		if (in_valid)
		begin
			s_d.mid_valid  = 1'b1;
			s_d.mid.left   = mul_q15(yv[0], {1'b0, s_d.gain});
			s_d.mid.right  = mul_q15(yv[1], {1'b0, s_d.gain});
		end

		// 8x stream: scaling and dither
		if (os_valid)
		begin
			x[0] = os_pair.left;
			x[1] = os_pair.right;
			if (s_q.ctrl[CTRL_NOISE_ON])
			begin
				s_d.dith_ph = !s_q.dith_ph;
				dv = s_q.dith_ph ? DITHER_LO : DITHER_HI;
			end
			else
				dv = '0;
			for (int c = 0; c < 2; c++)
			begin
				sc = mul_q15($signed(x[c]), SCALE_3DB);
				s_d.ns_v[c] = sat_aw(40'(sc) + 40'(dv));
			end
		end

		// shaper: runs on its own divided rate, far above the 8x stream
		if (s_q.div_cnt == 8'(SHAPER_DIV - 1))
		begin
			s_d.div_cnt = '0;
			for (int c = 0; c < 2; c++)
			begin
				if (s_q.ctrl[CTRL_ORDER])
					fb = (EW+4)'(-4 * $signed(s_q.err[c][0]) + 6 * $signed(s_q.err[c][1])
						- 4 * $signed(s_q.err[c][2]) + $signed(s_q.err[c][3]));
				else
					fb = (EW+4)'(-3 * $signed(s_q.err[c][0]) + 3 * $signed(s_q.err[c][1])
						- $signed(s_q.err[c][2]));
				u = (EW+4)'($signed(s_q.ns_v[c])) + fb;
				if (u > lim)
					u = lim;
				else if (u < -lim)
					u = -lim;
				q = (u >= 0) ? (EW+4)'(1) <<< (AW - 1) : -((EW+4)'(1) <<< (AW - 1));
				s_d.err[c][3] = s_q.err[c][2];
				s_d.err[c][2] = s_q.err[c][1];
				s_d.err[c][1] = s_q.err[c][0];
				s_d.err[c][0] = EW'(q - u);
				s_d.bits[c]   = (u >= 0);
			end
		end
		else
			s_d.div_cnt = s_q.div_cnt + 8'h01;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q          <= '0;
			s_q.wreq     <= 1'b1;
			s_q.ctrl     <= CTRL_RST;
			s_q.target   <= TGT_RST;
			s_q.fade_step_delay      <= FSS_RST;
			s_q.exp_pt   <= GAIN_MAX;
			s_q.gain     <= GAIN_MAX;
		end
		else
			s_q <= s_d;
	end

	assign avs_readdata     = s_q.rdata;
	assign avs_waitrequest  = s_q.wreq;
	assign mid_valid        = s_q.mid_valid;
	assign mid_pair         = s_q.mid;
	assign bit_out          = s_q.bits;
	assign shaper_order_sel = s_q.ctrl[CTRL_ORDER];

endmodule : adpf_top

`default_nettype wire

/* File: tb/adpf_monitor.sv */
// Purpose: port checker for adpf_top
// Assumes: one clock, async active-low reset
// Notes:   bound below
`timescale 1ns/10ps
`default_nettype none
module adpf_monitor
	import adpf_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// register bus
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// streams
	input wire logic        in_valid,
	input wire logic        mid_valid,
	input wire adpf_pair_t  mid_pair,
	input wire logic [1:0]  bit_out,
	input wire logic        shaper_order_sel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	bus_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without request");
	mid_follow_a: assert property (in_valid |=> mid_valid)
		else $error("sample not passed on");
	mid_cause_a: assert property (mid_valid |-> $past(in_valid))
		else $error("sample out of nothing");
	mid_hold_a: assert property (!mid_valid |-> $stable(mid_pair))
		else $error("mid pair moved");
	peak_limit_a: assert property (!avs_waitrequest && avs_read && avs_address == ADDR_PEAK
		|-> avs_readdata[15:0] <= 16'h7d72 && avs_readdata[31:16] <= 16'h7d72)
		else $error("peak above limit");
	order_src_a: assert property ($changed(shaper_order_sel) |-> $past(avs_write, 1) || $past(avs_write, 2))
		else $error("order changed unasked");
	bit_hold_a: assert property ($changed(bit_out) |=> $stable(bit_out))
		else $error("bit held one cycle");
endmodule : adpf_monitor
bind adpf_top adpf_monitor i_adpf_monitor (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .in_valid, .mid_valid, .mid_pair, .bit_out, .shaper_order_sel);
`default_nettype wire

/* File: tb/adpf_src.sv */
// Purpose: upstream stream stages feeding adpf_top
// Assumes: bench starts each stream and stops only the in_run stream
// Notes:   one pair every fourth cycle
`timescale 1ns/10ps
`default_nettype none
module adpf_src
	import adpf_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// bench commands
	input  wire logic       in_run,
	input  wire adpf_pair_t in_val,
	input  wire logic       os_run,
	// streams into the block
	output logic            in_valid,
	output adpf_pair_t      in_pair,
	output logic            os_valid,
	output adpf_pair_t      os_pair
);
	logic [1:0] ph_q;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ph_q     <= 2'h0;
			in_valid <= 1'b0;
			os_valid <= 1'b0;
		end
		else
		begin
			ph_q     <= ph_q + 2'h1;
			in_valid <= in_run && ph_q == 2'h3;
			os_valid <= os_run && ph_q == 2'h1;
		end
	end
	// off a pulse the lines carry junk, not the last value
	assign in_pair = in_valid ? in_val : ~in_val;
	assign os_pair = os_valid ? '0 : '1;
endmodule : adpf_src
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for adpf_top
// Assumes: 40 MHz clock, shaper divider 2
// Notes:   audio comes from adpf_src
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import adpf_pkg::*;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, s1, s2;
	logic        avs_waitrequest, in_valid, mid_valid, os_valid, shaper_order_sel;
	logic        in_run = 1'b0;
	logic        os_run = 1'b0;
	adpf_pair_t  in_val = '0;
	adpf_pair_t  in_pair, mid_pair, os_pair;
	logic [1:0]  bit_out;
	int          bad_count = 0;
	int          n_checks = 0;
	int          c0, c1;
	always #12.5 core_clk = ~core_clk;
	adpf_top #(.SHAPER_DIV(2)) i_adpf_top (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .in_valid, .in_pair, .mid_valid,
		.mid_pair, .os_valid, .os_pair, .bit_out, .shaper_order_sel);
	adpf_src i_adpf_src (.core_clk, .arst_n, .in_run, .in_val, .os_run, .in_valid, .in_pair,
		.os_valid, .os_pair);
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
		if (k >= 50)
		begin
			bad_count++;
			summarize();
		end
	endtask : bus
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, {8'h0, e}, {8'h0, q});
	endtask : rc
	// run n input pairs, then let the last result land
	task automatic samples(input int n);
		int k, t;
		k = 0;
		t = 0;
		in_run <= 1'b1;
		while (k < n && t < 20000)
		begin
			@(posedge core_clk);
			t++;
			if (in_valid === 1'b1)
				k++;
		end
		in_run <= 1'b0;
		if (k < n)
		begin
			bad_count++;
			summarize();
		end
		repeat (2) @(posedge core_clk);
	endtask : samples
	task automatic ones(output int c);
		c = 0;
		repeat (8192)
		begin
			@(posedge core_clk);
			c += int'(bit_out[0] === 1'b1);
		end
	endtask : ones
	initial
	begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rc(ADDR_CTRL, 32'h3, "ctrl");
		rc(ADDR_FADE, 32'h0, "fade");
		rc(ADDR_STAT, 32'h7fff, "stat");
		rc(3'h5, 32'h0, "unmapped");
		wr(ADDR_PEAK, 32'hffffffff);
		rc(ADDR_PEAK, 32'h0, "peak ro");
		wr(ADDR_CTRL, 32'h0);
		in_val <= '{20'sd1000, -20'sd1000};
		samples(4);
		chk("mid", {20'd999, 20'hffc18}, mid_pair);
		rc(ADDR_PEAK, 32'h003e_003e, "peak");
		in_val <= '{-20'sd20000, 20'sh7ffff};
		samples(2);
		in_val <= '{20'sd16, 20'sd16};
		samples(2);
		rc(ADDR_PEAK, 32'h7d72_04e2, "peak");
		rc(ADDR_PEAK, 32'h0, "peak clr");
		for (int f = 0; f < 4; f += 3)
		begin
			wr(ADDR_CTRL, 32'h0);
			wr(ADDR_FADE, {6'h0, 10'(f), 16'h3ff});
			wr(ADDR_CTRL, 32'h4);
			samples(20);
			bus(1'b0, ADDR_STAT, 32'h0, s1);
			samples(60);
			bus(1'b0, ADDR_STAT, 32'h0, s2);
			chk("slew", 40'd30, {25'h0, s1[14:0] - s2[14:0]});
			chk("steps", 40'(30 / (f + 2)), {30'h0, s2[25:16] - s1[25:16]});
		end
		wr(ADDR_CTRL, 32'h0);
		samples(2);
		bus(1'b0, ADDR_STAT, 32'h0, s1);
		chk("full", 40'h7fff, {25'h0, s1[14:0]});
		rc(ADDR_FADE, 32'h3_03ff, "kept");
		wr(ADDR_FADE, 32'h1);
		wr(ADDR_CTRL, 32'h4);
		samples(1200);
		bus(1'b0, ADDR_STAT, 32'h0, s1);
		samples(40);
		rc(ADDR_STAT, s1, "rest");
		chk("moved", 40'h1, 40'(s1[14:0] < 15'h7fff && s1[25:16] == 10'h1));
		wr(ADDR_CTRL, 32'h3);
		in_val <= '{20'sd1000, -20'sd1000};
		samples(200);
		s1 = 32'(mid_pair.left);
		s2 = 32'(mid_pair.right);
		samples(200);
		chk("adapt", 40'h1, 40'($signed(mid_pair.left) < $signed(s1[19:0])));
		chk("adapt r", 40'h1, 40'($signed(mid_pair.right) > $signed(s2[19:0])));
		wr(ADDR_CTRL, 32'h1);
		samples(2);
		s1 = 32'(mid_pair.left);
		samples(100);
		chk("held", {20'h0, s1[19:0]}, {20'h0, mid_pair.left});
		wr(ADDR_CTRL, 32'h2);
		samples(200);
		chk("decay", 40'h1, 40'($signed(mid_pair.left) > $signed(s1[19:0])));
		wr(ADDR_CTRL, 32'h10);
		chk("order", 40'h1, {39'h0, shaper_order_sel});
		wr(ADDR_CTRL, 32'h0);
		chk("order", 40'h0, {39'h0, shaper_order_sel});
		os_run <= 1'b1;
		ones(c0);
		chk("balance", 40'h1, 40'(c0 > 4064 && c0 < 4128));
		wr(ADDR_CTRL, 32'h8);
		ones(c1);
		chk("dither", 40'h1, 40'(c1 > c0 + 16));
		summarize();
	end
endmodule : testbench
`default_nettype wire
